// ---- src/storage_read_if.sv ----
// Storage read interface: byte masking, parity check, error qualify, reference start.
// Assumes microsequencer decodes are single-cycle synchronous strobes on ref_clk.
`timescale 1ns/1ps
module storage_read_if (
  input wire logic ref_clk,                      // 40 MHz clock
  input wire logic rst,                          // Resync_request reset, active high
  // Avalon-MM slave
  input wire logic [3:0] avs_address,            // Byte address
  input wire logic avs_read,                     // Read request
  input wire logic avs_write,                    // Write request
  input wire logic [31:0] avs_writedata,         // Write data
  input wire logic [3:0] avs_byteenable,         // Byte enables
  output logic [31:0] avs_readdata,              // Read data
  output logic avs_waitrequest,                  // Wait request
  // Microsequencer side
  input wire logic addr_load_op,                 // Address-load decode
  input wire logic data_load_op,                 // Data-load decode
  input wire logic store_word_op,                // Word read decode
  input wire logic store_byte_op,                // Byte read decode
  input wire logic maint_protect_access,         // Console protect read/write
  input wire logic [4:0] src_field,              // Source register field
  input wire logic [storage_read_pkg::ADDR_W-1:0] addr_in, // Address to load
  output logic resync_request,                   // Late address load seen
  output logic hold_next_microinstr,             // Block next fetch
  output logic access_start,                     // Start storage access
  output logic protect_reg_reference,            // Protect register access
  output logic block_access,                     // Maintenance block
  output logic store_in_progress,                // Write in progress
  output logic storage_read_gate,                // Storage data gate
  output logic protect_reg_read_gate,            // Protect data gate
  output logic [storage_read_pkg::ADDR_W-1:0] addr_ff, // Address register
  output logic [storage_read_pkg::WORD_W-1:0] read_result_ff, // Masked data
  output logic byte0_parity_err_n,               // Left byte error, low
  output logic byte1_parity_err_n,               // Right byte error, low
  output logic parity_trap,                      // Trap request
  output logic storage_error_ff,                 // Panel error indicator
  output logic console_busy_ff,                  // Console busy
  output logic [2:0] minor_cycle,                // Timing chain
  // Storage side
  input wire logic [storage_read_pkg::WORD_W-1:0] storage_data, // Read word
  input wire logic byte0_parity_bit,             // Stored parity, left
  input wire logic byte1_parity_bit,             // Stored parity, right
  input wire logic ecc_uncorrectable,            // Uncorrectable ECC
  input wire logic outside_protect_limits,       // Bounds fail
  input wire logic outside_installed_storage,    // Nonexistent storage
  input wire logic [storage_read_pkg::WORD_W-1:0] protect_reg_data // Protect data
);
  import storage_read_pkg::*;

  // Read-sequence states, one-hot
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_WAIT = 3'b010,
    ST_READ = 3'b100
  } rd_state_t;

  rd_state_t state_ff, nxt_state;  // Read sequencer
  logic [2:0] minor_ff;            // Minor cycle counter
  logic resync_ff;                 // Resync held to slice end
  logic [2:0] rd_cnt_ff;           // Minors since address load
  logic store_ff;                  // Store in progress flop
  logic byte_op_ff, word_op_ff;    // Pending read type
  logic [31:0] ctrl_ff;            // Control register
  logic [31:0] rdata_ff;           // Bus read data
  logic ack_ff;                    // Bus answer phase
  logic protect_ref_ff_q;          // Access was a protect register reference

  // Bit numbering: documented bit 0 is the MSB, bit 15 the LSB
  wire slice_start = (minor_ff == 3'h0);
  wire left_byte_select = ~addr_ff[0];
  wire protect_ref = (src_field == PROTECT_REG_A) || (src_field == PROTECT_REG_B);
  wire ecc_option_present = ctrl_ff[CTRL_ECC_BIT];

  // Timing chain
  initial begin
    if (WORD_W != 16) $error("storage_read_if: word must be 16 bits");
  end
  assign minor_cycle = minor_ff;

  // Block access in maintenance protect access
  assign block_access = ctrl_ff[CTRL_MAINT_BIT] & maint_protect_access;
  assign protect_reg_reference = addr_load_op & protect_ref;

  // Start storage only on an accepted address load
  assign access_start = addr_load_op & slice_start & ~protect_ref & ~block_access;

  // Late address load raises resync and blocks the next fetch
  assign resync_request = addr_load_op & ~slice_start;
  assign hold_next_microinstr = resync_request | resync_ff;

  // Parity: nibble partials then combine with stored bit (odd parity)
  wire even_bits_check = ^storage_data[15:12] ^ ^storage_data[11:8];
  wire odd_bits_check = ^storage_data[7:4] ^ ^storage_data[3:0];
  assign byte0_parity_err_n = even_bits_check ^ byte0_parity_bit;
  assign byte1_parity_err_n = odd_bits_check ^ byte1_parity_bit;
  wire checking = (state_ff == ST_READ);
  // Only storage data is parity checked; protect register data has no stored parity
  assign parity_trap = storage_read_gate & ~(byte0_parity_err_n & byte1_parity_err_n);

  // Raw and qualified storage error
  wire raw_err = ecc_option_present ? ecc_uncorrectable
                                    : ~(byte0_parity_err_n & byte1_parity_err_n);
  wire qual_err = storage_read_gate & raw_err & ~store_in_progress
                  & ~outside_protect_limits & ~outside_installed_storage;

  // Output enables: high half (bits 0-7), low half (bits 8-15)
  // The read-type decode arrives in the gate cycle itself, so a live strobe wins
  wire op_strobe = store_word_op | store_byte_op;
  wire word_sel = op_strobe ? store_word_op : word_op_ff;
  wire byte_sel = op_strobe ? (store_byte_op & ~store_word_op) : byte_op_ff;
  wire en_hi_word = word_sel;
  wire en_lo_word = word_sel;
  wire en_lo_left = byte_sel & left_byte_select;
  wire en_lo_right = byte_sel & ~left_byte_select;
  wire [WORD_W-1:0] src_word = protect_reg_read_gate ? protect_reg_data : storage_data;
  // High half only on a word read; byte reads leave it zero
  wire [7:0] hi_half = en_hi_word ? src_word[15:8] : 8'h00;
  wire [7:0] lo_half =
    en_lo_word ? src_word[7:0] :
    en_lo_left ? src_word[15:8] :
    en_lo_right ? src_word[7:0] : 8'h00;
  wire [WORD_W-1:0] masked = {hi_half, lo_half};

  // Read gates
  assign storage_read_gate = checking & ~protect_ref_ff_q;
  assign protect_reg_read_gate = checking & protect_ref_ff_q;
  assign store_in_progress = store_ff;

  // Read sequencer: address load, wait, then gate data in at minor five
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      ST_IDLE: begin
        if (addr_load_op & slice_start & ~block_access) nxt_state = ST_WAIT;
      end
      ST_WAIT: begin
        if (data_load_op) nxt_state = ST_IDLE;             // A write
        else if (rd_cnt_ff == 3'(GATE_MINOR - 1)) nxt_state = ST_READ;
      end
      ST_READ: begin
        nxt_state = ST_IDLE;                               // One gate cycle
      end
      default: nxt_state = ST_IDLE;
    endcase
  end

  // Minor cycle chain, resync hold and sequencer
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      minor_ff <= 3'h0;
      resync_ff <= 1'b0;
      state_ff <= ST_IDLE;
      rd_cnt_ff <= 3'h0;
    end else begin
      minor_ff <= minor_ff + 3'h1;
      if (minor_ff == 3'(MINORS_PER_SLICE - 1)) resync_ff <= 1'b0; // Re-run next slice
      else if (resync_request) resync_ff <= 1'b1;
      state_ff <= nxt_state;
      rd_cnt_ff <= (state_ff == ST_WAIT) ? rd_cnt_ff + 3'h1 : 3'h0;
    end
  end

  // Address register, read type, store flop
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      addr_ff <= '0;
      byte_op_ff <= 1'b0;
      word_op_ff <= 1'b0;
      store_ff <= 1'b0;
      protect_ref_ff_q <= 1'b0;
    end else begin
      if (addr_load_op & slice_start) begin
        addr_ff <= addr_in;
        protect_ref_ff_q <= protect_ref;
      end
      if (store_word_op | store_byte_op) begin
        word_op_ff <= store_word_op;
        byte_op_ff <= store_byte_op & ~store_word_op;
      end
      if (data_load_op & (minor_ff == 3'(STORE_MINOR))) store_ff <= 1'b1;
      else if (slice_start) store_ff <= 1'b0;
    end
  end

  // Masked result capture
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) read_result_ff <= '0;
    else if (checking) read_result_ff <= masked;
  end

  // Panel flag and console busy; error set wins over software clear
  // Writes land in the answer cycle, when waitrequest is low
  wire bus_wr = avs_write & ack_ff;
  wire wr_ctrl = bus_wr & (avs_address == OFS_CTRL);
  wire wr_stat = bus_wr & (avs_address == OFS_STATUS) & avs_byteenable[0];
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      storage_error_ff <= 1'b0;
      console_busy_ff <= 1'b0;
    end else begin
      if (qual_err) storage_error_ff <= 1'b1;
      else if (wr_stat & avs_writedata[STAT_PE_BIT]) storage_error_ff <= 1'b0;
      if (qual_err) console_busy_ff <= 1'b0;
      else if (wr_ctrl & avs_byteenable[0] & avs_writedata[CTRL_BUSY_BIT])
        console_busy_ff <= 1'b1;
    end
  end

  // Bus decode, unmapped reads zero
  wire [31:0] status_word = {29'h0, resync_ff, console_busy_ff, storage_error_ff};
  wire [31:0] rd_mux =
    (avs_address == OFS_CTRL) ? ctrl_ff :
    (avs_address == OFS_STATUS) ? status_word :
    (avs_address == OFS_DATA) ? {16'h0000, read_result_ff} : 32'h0000_0000;

  // One wait state per access, then answer
  assign avs_waitrequest = (avs_read | avs_write) & ~ack_ff;
  assign avs_readdata = rdata_ff;
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      ack_ff <= 1'b0;
      rdata_ff <= 32'h0000_0000;
      ctrl_ff <= CTRL_RESET;
    end else begin
      ack_ff <= (avs_read | avs_write) & ~ack_ff;
      if (avs_read & ~ack_ff) rdata_ff <= rd_mux;
      if (wr_ctrl & avs_byteenable[0]) ctrl_ff <= {30'h0, avs_writedata[1:0]};
    end
  end
endmodule

// ---- src/storage_read_pkg.sv ----
// Constants for the storage read interface: widths, minor-cycle timing, register map.
// Assumes one 40 MHz clock; one clock cycle stands for one minor-cycle step.
//
// Summary of operation
// - Storage reads always fetch full 16-bit words.
// - Word read passes fetched word unmodified.
// - Byte read zeros half, chosen by address bit 15.
// - Byte result right-justified, upper eight bits zero.
// - Two output enables: low half, high half.
// - Left byte select is inverse of bit 15.
// - Each byte odd-parity checked with its bit.
// - Left checker combines nibble partials with parity bit.
// - Mismatch drives byte error low, to display and trap.
// - Raw error from ECC or parity by option.
// - Error recognised only when no store in progress.
// - Error qualified by protect limits and installed storage.
// - Qualified error sets panel flag, clears console busy.
// - Write takes address load then data load.
// - Read data valid five minor cycles after address load.
// - Late address load raises resync, holds next microinstruction.
// - Resync re-executes address load next slice start.
// - Access start only without protect reference or block.
// - Protect reference when source names register 1E/1F.
// - Block access in maintenance protect register read/write.
// - Separate gates for storage and protect register data.
// - Store in progress set by data load in cycle one.
// - Read gate at E400 unless next is data load.
package storage_read_pkg;
  localparam int WORD_W = 16;            // Storage word width
  localparam int ADDR_W = 16;            // Address register width
  localparam int MINORS_PER_SLICE = 8;   // Minor cycles per time slice
  localparam int READ_MINORS = 5;        // Address load to read data
  localparam int GATE_MINOR = 4;         // Wait ends in minor four; read gate rises in minor five
  localparam int STORE_MINOR = 1;        // Data load minor for a store
  localparam logic [4:0] PROTECT_REG_A = 5'h1e; // Protect address holders
  localparam logic [4:0] PROTECT_REG_B = 5'h1f;
  // Register map (byte addresses, word aligned)
  localparam logic [3:0] OFS_CTRL = 4'h0;   // Option and mode control
  localparam logic [3:0] OFS_STATUS = 4'h4; // Error and busy status
  localparam logic [3:0] OFS_DATA = 4'h8;   // Last masked read result
  // Field positions
  localparam int CTRL_ECC_BIT = 0;       // ECC option present
  localparam int CTRL_MAINT_BIT = 1;     // Maintenance mode
  localparam int CTRL_BUSY_BIT = 2;      // Write one sets console busy
  localparam int STAT_PE_BIT = 0;        // Latched storage error
  localparam int STAT_BUSY_BIT = 1;      // Console busy
  localparam int STAT_RESYNC_BIT = 2;    // Resync pending
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
endpackage

// ---- verif/storage_array_model.sv ----
// Storage array stand-in: returns a word and its byte parity bits.
// Assumes the bench supplies the addressed word and the parity faults.
`timescale 1ns/1ps
module storage_array_model (
  input wire logic [2:0] minor_cycle, // Timing chain of the block
  input wire logic [15:0] word, // Content at the loaded address
  input wire logic bad0, // Break left byte parity
  input wire logic bad1, // Break right byte parity
  output logic [15:0] storage_data, // Word toward the block
  output logic byte0_parity_bit, // Stored parity, left byte
  output logic byte1_parity_bit // Stored parity, right byte
);
  // Whole word in the data minor and also in minors 3 and 7; junk in the other minors
  assign storage_data = (minor_cycle == 3'd5) ? word : ~word ^ {8{minor_cycle[1:0]}};
  // Odd parity per byte, broken only on command
  assign byte0_parity_bit = ~^word[15:8] ^ bad0;
  assign byte1_parity_bit = ~^word[7:0] ^ bad1;
endmodule

// ---- verif/storage_read_if_sva.sv ----
// Checker for the storage read interface, bound to its top module.
// Assumes one clock domain and the resync_request high reset.
`timescale 1ns/1ps
module storage_read_if_sva (
  input wire logic ref_clk, rst, addr_load_op, data_load_op, // Clock and decodes
  input wire logic store_word_op, store_byte_op, resync_request, hold_next_microinstr, // Ops
  input wire logic access_start, block_access, store_in_progress, storage_read_gate, // Flags
  input wire logic byte0_parity_err_n, byte1_parity_err_n, parity_trap, // Parity
  input wire logic storage_error_ff, console_busy_ff, byte0_parity_bit, byte1_parity_bit, // Err
  input wire logic [4:0] src_field, // Source field
  input wire logic [2:0] minor_cycle, // Timing chain
  input wire logic [15:0] addr_in, addr_ff, read_result_ff, storage_data // Data paths
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  a_start_cond: assert property (access_start |-> addr_load_op && minor_cycle == 3'd0 &&
    src_field[4:1] != 4'hf && !block_access) else $error("bad access start");
  a_late_resync: assert property (addr_load_op && minor_cycle != 3'd0 |->
    resync_request && hold_next_microinstr) else $error("late load no resync");
  a_addr_load: assert property (addr_load_op && minor_cycle == 3'd0 |=>
    addr_ff == $past(addr_in)) else $error("address not loaded");
  a_addr_hold: assert property (addr_load_op && minor_cycle != 3'd0 |=>
    $stable(addr_ff)) else $error("address moved on late load");
  a_read_gate: assert property (access_start ##1 (!data_load_op)[*4] |=>
    storage_read_gate) else $error("read gate missing");
  a_gate_cancel: assert property (access_start ##1 data_load_op |-> ##4
    !storage_read_gate) else $error("gate on write");
  a_byte_mask: assert property (storage_read_gate && store_byte_op |=> read_result_ff ==
    {8'h00, $past(addr_ff[0]) ? $past(storage_data[7:0]) : $past(storage_data[15:8])})
    else $error("byte mask wrong");
  a_word_pass: assert property (storage_read_gate && store_word_op |=>
    read_result_ff == $past(storage_data)) else $error("word altered");
  a_parity_chk: assert property (storage_read_gate |->
    byte0_parity_err_n == ^{storage_data[15:8], byte0_parity_bit} &&
    byte1_parity_err_n == ^{storage_data[7:0], byte1_parity_bit})
    else $error("parity check wrong");
  a_trap_err: assert property (storage_read_gate && !(byte0_parity_err_n &&
    byte1_parity_err_n) |-> parity_trap) else $error("no parity trap");
  a_store_flag: assert property (data_load_op && minor_cycle == 3'd1 |=>
    store_in_progress) else $error("store flag not set");
  a_err_busy: assert property ($rose(storage_error_ff) |-> !console_busy_ff)
    else $error("busy not cleared");
endmodule
bind storage_read_if storage_read_if_sva i_sva (.*);

// ---- verif/tb.sv ----
// Bench: random reads, byte masks, parity faults, late loads and stores.
// Assumes the storage model supplies data in minor five of a slice.
`timescale 1ns/1ps
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin err_count++; \
  $display("[FAIL] t=%0t got=%h exp=%h", $time, a, b); end end
module tb;
  import storage_read_pkg::*;
  logic ref_clk = 1'b0, rst = 1'b1, avs_read = 1'b0, avs_write = 1'b0, wreq; // Clock, bus
  logic [3:0] avs_address = 4'h0; // Bus address
  logic [31:0] avs_writedata = 32'h0, avs_readdata, rd, lf = 32'h0000_2b77; // Bus data, LFSR
  logic ld = 1'b0, dl = 1'b0, wop = 1'b0, bop = 1'b0, mpa = 1'b0, unc = 1'b0; // Decodes
  logic olim = 1'b0, omem = 1'b0, bad0 = 1'b0, bad1 = 1'b0, p0, p1; // Storage side
  logic resync, acc, gate, prg, e0_n, e1_n, serr, busy; // Observed outputs
  logic ecc, maint, late, store, byte_op, exp_acc, exp_gate, exp_err, exp_prot; // Choices
  logic [4:0] sf = 5'h00; // Source field
  logic [15:0] addr_in = 16'h0, word = 16'h0, pdata = 16'h0, sdata, res; // Words
  logic [2:0] minor; // Timing chain
  int err_count = 0, n_compared = 0; // Tallies
  always #12.5 ref_clk = ~ref_clk;
  storage_read_if i_dut (.ref_clk(ref_clk), .rst(rst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(4'hf), .avs_readdata(avs_readdata), .avs_waitrequest(wreq),
    .addr_load_op(ld), .data_load_op(dl), .store_word_op(wop), .store_byte_op(bop),
    .maint_protect_access(mpa), .src_field(sf), .addr_in(addr_in), .resync_request(resync),
    .hold_next_microinstr(), .access_start(acc), .protect_reg_reference(), .block_access(),
    .store_in_progress(), .storage_read_gate(gate), .protect_reg_read_gate(prg), .addr_ff(),
    .read_result_ff(res), .byte0_parity_err_n(e0_n), .byte1_parity_err_n(e1_n),
    .parity_trap(), .storage_error_ff(serr), .console_busy_ff(busy), .minor_cycle(minor),
    .storage_data(sdata), .byte0_parity_bit(p0), .byte1_parity_bit(p1),
    .ecc_uncorrectable(unc), .outside_protect_limits(olim), .outside_installed_storage(omem),
    .protect_reg_data(pdata));
  storage_array_model i_mem (.minor_cycle(minor), .word(word), .bad0(bad0), .bad1(bad1),
    .storage_data(sdata), .byte0_parity_bit(p0), .byte1_parity_bit(p1));
  // Galois LFSR, fixed start so runs repeat
  function automatic logic [31:0] nxt_rand(input logic [31:0] s);
    return {s[30:0], 1'b0} ^ (s[31] ? 32'h0040_0007 : 32'h0000_0000);
  endfunction
  // Expected fan-out result for word or byte read
  function automatic logic [15:0] exp_mask(input logic b, input logic sr15, input logic [15:0] w);
    return !b ? w : (sr15 ? {8'h00, w[7:0]} : {8'h00, w[15:8]});
  endfunction
  // One bus cycle; request held until waitrequest seen low at an edge
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    avs_address <= a;
    avs_write <= w;
    avs_read <= !w;
    avs_writedata <= d;
    do @(posedge ref_clk); while (wreq !== 1'b0);
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge ref_clk);
  endtask
  // Stop at the edge that ends the given minor
  task automatic to_minor(input logic [2:0] m);
    do @(posedge ref_clk); while (minor !== m);
  endtask
  task automatic complete_run;
    if (err_count == 0 && n_compared > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // Hang guard, well beyond forty passes
  initial begin
    repeat (20000) @(posedge ref_clk);
    err_count++;
    complete_run;
  end
  initial begin
    repeat (12) @(posedge ref_clk);
    rst <= 1'b0;
    @(posedge ref_clk);
    bus(1'b0, 4'hc, 32'h0); `CHK(rd, 32'h0) // Unmapped place reads zero
    repeat (40) begin
      lf = nxt_rand(lf);
      {ecc, maint, late, store, byte_op, bad0, bad1, unc, mpa} = lf[8:0];
      olim <= lf[9] & lf[10];
      omem <= lf[11] & lf[12];
      sf <= lf[13] ? {4'hf, lf[14]} : lf[18:14];
      word <= lf[31:16];
      addr_in <= lf[27:12];
      pdata <= ~lf[31:16];
      exp_acc = !(lf[13] || lf[18:15] == 4'hf) && !(maint && lf[0]);
      exp_gate = exp_acc && !store;
      exp_prot = (lf[13] || lf[18:15] == 4'hf) && !(maint && lf[0]) && !store;
      exp_err = exp_gate && (ecc ? lf[1] : (lf[3] | lf[2])) && !(lf[9] & lf[10]) &&
        !(lf[11] & lf[12]);
      bus(1'b1, OFS_CTRL, {29'h0, 1'b1, maint, ecc});
      bus(1'b1, OFS_STATUS, 32'h0000_0001);
      bus(1'b0, OFS_STATUS, 32'h0); `CHK(rd[1:0], 2'b10)
      if (late) begin
        to_minor(3'd2);
        ld <= 1'b1;
        @(posedge ref_clk); `CHK(resync, 1'b1)
        ld <= 1'b0;
      end
      // Slice starts with a blockpoint, so the load lands in minor zero
      to_minor(3'd7);
      ld <= 1'b1;
      @(posedge ref_clk); `CHK(acc, exp_acc)
      ld <= 1'b0;
      dl <= store;
      @(posedge ref_clk);
      dl <= 1'b0;
      to_minor(3'd4);
      wop <= !byte_op;
      bop <= byte_op;
      @(posedge ref_clk); `CHK(gate, exp_gate)
      `CHK(prg, exp_prot)
      if (exp_gate) `CHK({e0_n, e1_n}, {!lf[3], !lf[2]})
      wop <= 1'b0;
      bop <= 1'b0;
      @(posedge ref_clk); `CHK(serr, exp_err)
      `CHK(busy, !exp_err)
      if (exp_gate) `CHK(res, exp_mask(byte_op, lf[12], lf[31:16]))
      if (exp_prot) `CHK(res, exp_mask(byte_op, lf[12], ~lf[31:16]))
    end
    complete_run;
  end
endmodule
